// ===== hw/dct_core.sv
module dct_core
  import dct_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_addr,
  input wire logic i_odt,
  output logic o_odt_en,
  output logic [1:0] o_rtt_sel,
  output logic [1:0] o_ocd_drive,
  output logic o_pd_timing
);
  import dct_pkg::*;

  // Last sampled termination request, to spot its edges
  logic odt_last_reg;
  // Previous clock enable level, to spot power-down exit
  logic cke_last_reg;
  // Cycles left in which power-down termination timing still applies
  logic [DLY_W-1:0] axpd_reg;
  logic [DLY_W-1:0] axpd_next;
  // Termination state as seen by the termination delay
  logic odt_state;
  // Wait flags of the three delay units: a unit is busy while a change
  // is still pending, which the settle checks below rely on
  logic odt_busy;
  logic rtt_busy;
  logic ocd_busy;

  // Every other command is ignored; only mode writes matter to this block
  // Command decode: a mode register set needs clock enable high
  wire mrs_hit = i_cke && !i_cs_n && !i_ras_n && !i_cas_n && !i_we_n;
  wire emr1_hit = mrs_hit && (i_ba == BA_EMR1);
  // Termination value and calibration code ride on the address lines
  wire [1:0] rtt_new = {i_addr[RTT_HI_BIT], i_addr[RTT_LO_BIT]};
  wire [2:0] ocd_code = i_addr[OCD_LSB +: 3];

  // Only the two drive codes force the outputs; every other code releases them
  wire [1:0] drv_new = (ocd_code == OCD_DRV1) ? DRV_HIGH :
                       (ocd_code == OCD_DRV0) ? DRV_LOW : DRV_NORMAL;

  // Clock enable rising: the edge at which power-down is left
  wire cke_rise = i_cke && !cke_last_reg;
  // Power-down timing while clock enable is low, on the exit edge itself
  // and for eight edges after it; the exit edge counts because the
  // termination path is not yet back on the clock at that edge
  wire pd_timing = !i_cke || cke_rise || (axpd_reg != '0);
  // Any difference from the last sampled level is a termination request
  wire odt_chg = (i_odt != odt_last_reg);

  // Pick the latency for this termination edge. Power-down takes the
  // shortest legal count: a real pad path acts without the clock, so the
  // long end of the window is left as margin for it
  wire [DLY_W-1:0] on_cyc = pd_timing ? DLY_W'(AONPD_MIN_CYC) : DLY_W'(AOND_CK);
  wire [DLY_W-1:0] off_cyc = pd_timing ? DLY_W'(AOFPD_MIN_CYC) : DLY_W'(AOFD_CYC);
  // The new level decides which of the two latencies applies
  wire [DLY_W-1:0] odt_cyc = i_odt ? on_cyc : off_cyc;

  // Exit window counter: reloads on each power-down exit
  always_comb begin
    if (cke_rise) begin
      // Every exit restarts the full window
      axpd_next = DLY_W'(AXPD_CYC);
    end else if (axpd_reg != '0) begin
      // Count the window down one edge at a time
      axpd_next = axpd_reg - DLY_W'(1);
    end else begin
      // Window closed; stay at zero
      axpd_next = axpd_reg;
    end
  end

  // Edge trackers; clock enable is only sampled, its pulse width is trusted
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // Reset leaves the block as if just out of power-down, so the first
      // edges after release still count as the exit window
      odt_last_reg <= 1'b0;
      cke_last_reg <= 1'b0;
      axpd_reg <= '0;
      o_pd_timing <= 1'b1;
    end else begin
      // Sample both pins and advance the window
      odt_last_reg <= i_odt;
      cke_last_reg <= i_cke;
      axpd_reg <= axpd_next;
      o_pd_timing <= !i_cke || (axpd_next != '0);
    end
  end

  // Termination switch; in power-down the input acts without a clock,
  // modelled here by the shortest legal latency in core cycles
  dct_delay #(.CNT_W(DLY_W), .DAT_W(1), .RST_VAL(1'b0)) u_odt_dly (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(odt_chg),
    .i_cycles(odt_cyc),
    .i_data(i_odt),
    .o_data(odt_state),
    .o_busy(odt_busy)
  );

  // Termination value update after an extended mode register write
  // One edge of wait fits inside the update limit at this clock
  dct_delay #(.CNT_W(DLY_W), .DAT_W(2), .RST_VAL(RTT_RST)) u_rtt_dly (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(emr1_hit),
    .i_cycles(DLY_W'(TMOD_CYC)),
    .i_data(rtt_new),
    .o_data(o_rtt_sel),
    .o_busy(rtt_busy)
  );

  // Calibration drive state; spacing of mode writes is left to the controller
  // A back-to-back write overrides the pending one; the latest wins
  dct_delay #(.CNT_W(DLY_W), .DAT_W(2), .RST_VAL(DRV_NORMAL)) u_ocd_dly (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_load(emr1_hit),
    .i_cycles(DLY_W'(TOIT_CYC)),
    .i_data(drv_new),
    .o_data(o_ocd_drive),
    .o_busy(ocd_busy)
  );

  // The output comes straight from the delay unit's register
  assign o_odt_en = odt_state;

  // Device-side checks; the controller's spacing is kept by its model
  // Power-down turn-on lands inside its window
  a_odt_pd_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (odt_chg && i_odt && pd_timing) ##1 i_odt |=> o_odt_en)
    else $error("termination late turning on in power-down");

  // Power-down turn-off lands inside its window
  a_odt_pd_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (odt_chg && !i_odt && pd_timing) ##1 !i_odt |=> !o_odt_en)
    else $error("termination late turning off in power-down");

  // Synchronous turn-on takes exactly two edges
  a_odt_sync_on: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (odt_chg && i_odt && !pd_timing) ##1 i_odt[*2] |-> !$past(o_odt_en) ##1 o_odt_en)
    else $error("synchronous termination turn-on not at two cycles");

  // New termination value applied within the update limit
  a_rtt_update: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    emr1_hit ##1 !emr1_hit |=> (o_rtt_sel == $past(rtt_new, 2)))
    else $error("termination setting not applied in time");

  // Drive state follows the calibration code within the limit
  a_ocd_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    emr1_hit ##1 !emr1_hit |=> (o_ocd_drive == $past(drv_new, 2)))
    else $error("calibration drive state late");

  // Delay units idle once their change is applied
  a_dly_settle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    emr1_hit ##1 !emr1_hit |=> !rtt_busy && !ocd_busy)
    else $error("delay unit stuck busy");

  // No termination wait outlasts the longest latency of three edges
  a_odt_settle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    odt_chg ##1 (!odt_chg)[*3] |=> !odt_busy)
    else $error("termination delay stuck busy");

  // Synchronous turn-off holds the old level for three edges, then drops
  a_odt_sync_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (odt_chg && !i_odt && !pd_timing && o_odt_en && !odt_busy) ##1 (!i_odt)[*3]
      |-> o_odt_en ##1 !o_odt_en)
    else $error("synchronous termination turn-off not at three cycles");

  // Clock enable low is reported as power-down timing at the next edge
  a_pd_enter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_cke |=> o_pd_timing)
    else $error("power-down timing flag missing while enable low");

  // After an exit the flag stands for eight edges
  a_pd_exit_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cke_rise |=> o_pd_timing[*8])
    else $error("power-down timing flag dropped too early after exit");

  // With enable kept high the flag clears once the window has passed
  a_pd_exit_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cke_rise ##1 i_cke[*8] |=> !o_pd_timing)
    else $error("power-down timing flag held too long after exit");

  // Termination value moves only on the edge after a mode write
  a_rtt_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_rtt_sel) |-> $past(emr1_hit, 2))
    else $error("termination setting changed without a mode write");

  // Drive state moves only on the edge after a mode write
  a_ocd_quiet: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(o_ocd_drive) |-> $past(emr1_hit, 2))
    else $error("calibration drive state changed without a mode write");
endmodule

// ===== hw/dct_delay.sv
// Loadable delay: the value given at load appears at o_data exactly
// i_cycles clock edges later; a new load restarts the wait.
module dct_delay #(
  parameter int CNT_W = 4,
  parameter int DAT_W = 2,
  parameter logic [DAT_W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_cycles,
  input wire logic [DAT_W-1:0] i_data,
  output logic [DAT_W-1:0] o_data,
  output logic o_busy
);
  logic [CNT_W-1:0] cnt_reg; // Edges still to wait
  logic [DAT_W-1:0] hold_reg; // Value waiting to be applied
  wire apply = (cnt_reg == CNT_W'(1)) && !i_load;

  // Countdown; the latest load wins so a late change is never lost
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_reg <= '0;
      hold_reg <= RST_VAL;
      o_data <= RST_VAL;
    end else begin
      if (i_load) begin
        cnt_reg <= i_cycles;
        hold_reg <= i_data;
      end else if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - CNT_W'(1);
      end
      if (apply) begin
        o_data <= hold_reg;
      end
    end
  end

  assign o_busy = (cnt_reg != '0);
endmodule

// ===== hw/dct_pkg.sv
package dct_pkg;
  // Core clock feeding this block, in picoseconds (100 MHz)
  localparam int CLK_PERIOD_PS = 10000;
  // Output access window bounds of the fastest grade
  localparam int TAC_MIN_PS = -400;
  localparam int TAC_MAX_PS = 400;

  // Width of every delay count handed to the delay unit
  localparam int DLY_W = 4;

  // Synchronous termination turn-on and turn-off latencies
  localparam int AOND_CK = 2;
  localparam int AOFD_CK_X10 = 25;
  // Half-cycle latency rounds up, the core has no falling-edge domain
  localparam int AOFD_CYC = (AOFD_CK_X10 + 9) / 10;

  // Power-down turn-on: from tAC(min)+2 ns to 2 tCK + tAC(max) + 1 ns
  localparam int AONPD_MIN_ADD_PS = 2000;
  localparam int AONPD_MAX_CK = 2;
  localparam int AONPD_MAX_ADD_PS = 1000;
  localparam int AONPD_MIN_RAW = (TAC_MIN_PS + AONPD_MIN_ADD_PS + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int AONPD_MIN_CYC = (AONPD_MIN_RAW < 1) ? 1 : AONPD_MIN_RAW;
  localparam int AONPD_MAX_CYC = (AONPD_MAX_CK * CLK_PERIOD_PS + TAC_MAX_PS
                                 + AONPD_MAX_ADD_PS) / CLK_PERIOD_PS;

  // Power-down turn-off: from tAC(min)+2 ns to 2.5 tCK + tAC(max) + 1 ns
  localparam int AOFPD_MIN_ADD_PS = 2000;
  localparam int AOFPD_MAX_CK_X10 = 25;
  localparam int AOFPD_MAX_ADD_PS = 1000;
  localparam int AOFPD_MIN_RAW = (TAC_MIN_PS + AOFPD_MIN_ADD_PS + CLK_PERIOD_PS - 1)
                                 / CLK_PERIOD_PS;
  localparam int AOFPD_MIN_CYC = (AOFPD_MIN_RAW < 1) ? 1 : AOFPD_MIN_RAW;
  localparam int AOFPD_MAX_CYC = (AOFPD_MAX_CK_X10 * CLK_PERIOD_PS / 10 + TAC_MAX_PS
                                 + AOFPD_MAX_ADD_PS) / CLK_PERIOD_PS;

  // Mode-register termination update and OCD drive delay, 0 to 12 ns
  localparam int TMOD_MAX_NS = 12;
  localparam int TOIT_MAX_NS = 12;
  localparam int TMOD_RAW = TMOD_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int TOIT_RAW = TOIT_MAX_NS * 1000 / CLK_PERIOD_PS;
  localparam int TMOD_CYC = (TMOD_RAW < 1) ? 1 : TMOD_RAW;
  localparam int TOIT_CYC = (TOIT_RAW < 1) ? 1 : TOIT_RAW;

  // Cycles after power-down exit during which asynchronous timing still holds
  localparam int AXPD_CYC = 8;

  // Extended mode register select and field positions
  localparam logic [2:0] BA_EMR1 = 3'h1;
  localparam int RTT_HI_BIT = 6;
  localparam int RTT_LO_BIT = 2;
  localparam int OCD_LSB = 7;

  // Calibration program codes
  localparam logic [2:0] OCD_EXIT = 3'h0;
  localparam logic [2:0] OCD_DRV1 = 3'h1;
  localparam logic [2:0] OCD_DRV0 = 3'h2;

  // Output driver state reported outward, and the termination value loaded at reset
  localparam logic [1:0] DRV_NORMAL = 2'h0;
  localparam logic [1:0] DRV_HIGH = 2'h1;
  localparam logic [1:0] DRV_LOW = 2'h2;
  localparam logic [1:0] RTT_RST = 2'h0;
endpackage

// ===== sim/dct_ctrl_model.sv
// Controller model: issues mode writes and drives enable and termination
module dct_ctrl_model (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_mrs,
  input wire logic [2:0] i_ba,
  input wire logic [13:0] i_code,
  input wire logic i_cke,
  input wire logic i_odt,
  output logic o_cke,
  output logic o_cmd_n,
  output logic [2:0] o_ba,
  output logic [13:0] o_addr,
  output logic o_odt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] gap_reg; // Edges since the last mode write, saturating
  logic [1:0] hold_reg; // Edges the enable has kept its level
  logic cke_reg; // Enable level at the last edge
  logic [2:0] ba_reg; // Last bank shown
  logic [13:0] addr_reg; // Last address shown
  // A request too soon after the last mode write is dropped, and so is one
  // with enable low or on the one edge just after an enable change
  wire logic mrs_ok = i_mrs && (gap_reg == 2'h2) && o_cke && (hold_reg != 2'h1);
  // Enable may only change once its level has stood three edges
  assign o_cke = (hold_reg == 2'h3) ? i_cke : cke_reg;
  // Only mode writes and deselects are driven: no activate, column, precharge,
  // refresh or write data is issued, so their spacing holds trivially
  assign o_cmd_n = ~mrs_ok;
  // Idle lines show the inverse of their last value, never a stale copy
  assign o_ba = mrs_ok ? i_ba : ~ba_reg;
  assign o_addr = mrs_ok ? i_code : ~addr_reg;
  // Termination passes straight through; the stimulus also moves it during power-down
  assign o_odt = i_odt;
  // Spacing counters and idle-line history
  always_ff @(posedge i_clk) begin
    ba_reg <= o_ba;
    addr_reg <= o_addr;
    cke_reg <= o_cke;
    if (i_sys_rst) begin
      gap_reg <= 2'h2;
      hold_reg <= 2'h3;
    end else begin
      gap_reg <= mrs_ok ? 2'h1 : ((gap_reg == 2'h2) ? gap_reg : gap_reg + 2'h1);
      hold_reg <= (o_cke != cke_reg) ? 2'h1 : ((hold_reg == 2'h3) ? hold_reg : hold_reg + 2'h1);
    end
  end
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the command timing core
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk, i_sys_rst, mrs, cke, odt; // Stimulus
  logic [2:0] ba;
  logic [13:0] code, a;
  logic [3:0] prev; // Last applied termination and drive
  logic [31:0] lf; // Random state
  int mismatches, compares;
  wire logic p_cke, p_cmd_n, p_odt;
  wire logic [2:0] p_ba;
  wire logic [13:0] p_addr;
  logic o_odt_en, o_pd_timing;
  logic [1:0] o_rtt_sel, o_ocd_drive;
  dct_ctrl_model u_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mrs(mrs), .i_ba(ba),
    .i_code(code), .i_cke(cke), .i_odt(odt), .o_cke(p_cke), .o_cmd_n(p_cmd_n),
    .o_ba(p_ba), .o_addr(p_addr), .o_odt(p_odt));
  dct_core uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cke(p_cke), .i_cs_n(p_cmd_n),
    .i_ras_n(p_cmd_n), .i_cas_n(p_cmd_n), .i_we_n(p_cmd_n), .i_ba(p_ba), .i_addr(p_addr),
    .i_odt(p_odt), .o_odt_en(o_odt_en), .o_rtt_sel(o_rtt_sel), .o_ocd_drive(o_ocd_drive),
    .o_pd_timing(o_pd_timing));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Applied termination and drive state after a mode write
  function automatic logic [3:0] exp_mode(input logic [13:0] ad);
    return {ad[6], ad[2], (ad[9:7] == 3'h1) ? 2'h1 : ((ad[9:7] == 3'h2) ? 2'h2 : 2'h0)};
  endfunction
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Inputs always move one nanosecond after the rising edge
  task automatic step();
    @(posedge i_clk);
    #1;
  endtask
  // One mode write, then the edge at which its result is due
  task automatic mode_write(input logic [2:0] b, input logic [13:0] ad);
    mrs = 1'b1;
    ba = b;
    code = ad;
    step();
    mrs = 1'b0;
    step();
  endtask
  // Termination change, old value until edge n, new value from it
  task automatic odt_case(input logic v, input int n);
    odt = v;
    for (int k = 0; k <= n; k++) begin
      step();
      check({3'h0, o_odt_en}, {3'h0, (k == n) ? v : ~v});
    end
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    i_sys_rst = 1'b1;
    mrs = 1'b0;
    ba = 3'h0;
    code = 14'h0000;
    cke = 1'b1;
    odt = 1'b0;
    lf = 32'h0000BD3A;
    mismatches = 0;
    compares = 0;
    repeat (6) step();
    check({o_odt_en, o_pd_timing, o_ocd_drive}, 4'h4);
    check({2'h0, o_rtt_sel}, 4'h0);
    i_sys_rst = 1'b0;
    // Every calibration code, with random termination bits and refused banks
    for (int i = 0; i < 8; i++) begin
      lf = lfsr_next(lf);
      a = {lf[13:10], 3'(i), lf[6:0]};
      mode_write(3'h1, a);
      prev = exp_mode(a);
      check({o_rtt_sel, o_ocd_drive}, prev);
      mode_write((lf[17:15] == 3'h1) ? 3'h0 : lf[17:15], ~a);
      check({o_rtt_sel, o_ocd_drive}, prev);
    end
    // Power-down: asynchronous termination, then the exit window
    repeat (3) step();
    cke = 1'b0;
    repeat (3) step();
    check({3'h0, o_pd_timing}, 4'h1);
    odt_case(1'b1, 1);
    odt_case(1'b0, 1);
    repeat (2) step();
    cke = 1'b1;
    step();
    odt_case(1'b1, 1);
    check({3'h0, o_pd_timing}, 4'h1);
    repeat (4) step();
    check({3'h0, o_pd_timing}, 4'h1);
    repeat (4) step();
    check({3'h0, o_pd_timing}, 4'h0);
    // Synchronous turn-on 2 and rounded turn-off 3, random idle gaps
    for (int i = 0; i < 10; i++) begin
      lf = lfsr_next(lf);
      repeat (lf[1:0]) step();
      odt_case(~odt, odt ? 3 : 2);
    end
    // A termination change on the exit edge itself still takes the short latency
    cke = 1'b0;
    repeat (4) step();
    cke = 1'b1;
    odt_case(~odt, 1);
    results();
  end
endmodule
